// ---- hdl/tsrs_sequencer.sv ----
// Purpose: Soft reset sequencer for the second remote terminal and monitor.
// Assumes: One clock; EEPROM answers each word request with i_ee_valid.
// Notes: Reloaded words leave on o_load towards the register and RAM space.
`timescale 1ns/1ps

// Notes on behaviour
// - Setting status bit 11 at address 0x0001 starts the terminal B reset.
// - Terminal B reset clears pending bits 2 and 4 and its run bit.
// - Terminal B reset clears only bits 15 to 10 of register 0x0009.
// - Terminal B reset zeroes 0x0021, 0x0023, 0x0027 and time tag 0x004B.
// - Terminal B reset reloads enables, its setup registers and both tables.
// - Shared enable registers are reloaded, affecting the other terminal too.
// - Terminal B reload is checked against the checksum at 0x01E0.
// - Terminal B auto-starts only with pin, image pin and bit 7, bit 5.
// - Image run bit 5 is kept only when both unlock words match.
// - Setting status bit 12 starts the monitor soft reset.
// - Monitor reset clears monitor enable and pending bit 1 of 0x0006.
// - Monitor reset zeroes 0x0008, stack pointers and time tag words.
// - Monitor reset reloads enables, configuration, time tag and tables.
// - Monitor reload is checked against the checksum at 0x005C.
// - Monitor reset resets stack pointers but never touches stack memory.
// - Monitor auto-starts only with pin, image pin and image bit 12.
// - Image monitor enable is kept only when both unlock words match.
// - Reset bits work alone or together; other terminals are untouched except for shared enables.
// - Reloaded words plus stored checksum must sum to zero, ignoring carry.
module tsrs_sequencer (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire tsrs_pkg::tsrs_host_req_t i_host,
  output logic [15:0] o_host_rdata,
  input wire logic i_terminal_b_enable,
  input wire logic i_monitor_enable,
  input wire logic [15:0] i_hw_pend_set,
  input wire logic [15:0] i_mon_pend_set,
  input wire logic [15:0] i_rt_pend_set,
  input wire logic i_tb_tt_tick,
  input wire logic i_mon_tt_tick,
  input wire logic i_mon_ptr_adv,
  output tsrs_pkg::tsrs_ee_req_t o_ee,
  input wire logic i_ee_valid,
  input wire logic [15:0] i_ee_data,
  output tsrs_pkg::tsrs_load_t o_load,
  output logic o_ready,
  output logic [15:0] o_master_cfg,
  input wire logic [15:0] i_copy_cfg,
  input wire logic [15:0] i_copy_unlock1,
  input wire logic [15:0] i_copy_unlock2,
  output logic [15:0] o_copy_cfg_image
);

  tsrs_pkg::tsrs_state_t state;
  logic cur_mon;
  logic [3:0] seg;
  logic [9:0] cnt;
  logic [15:0] sum;
  logic img_phase;
  logic [15:0] image_cfg;
  logic [15:0] image_pin;
  logic pin_ok;
  logic csum_ok;
  logic tb_req;
  logic mon_req;
  logic tb_err;
  logic mon_err;
  logic [15:0] hw_pend;
  logic [15:0] mon_pend;
  logic [15:0] rt_pend;
  logic [15:0] tb_regs [0:2];
  logic [15:0] tb_tt;
  logic [47:0] mon_tt;
  logic [15:0] mon_next_ptr;
  logic [15:0] mon_last_ptr;
  logic [15:0] next_rdata;
  logic clr_tb;
  logic clr_mon;
  logic fin_tb;
  logic fin_mon;
  logic auto_tb;
  logic auto_mon;
  logic host_wr_status;
  logic host_wr_cfg;

  function automatic logic [14:0] seg_start(input logic mon,
                                            input logic [3:0] idx);
    if (mon) begin
      return tsrs_pkg::MON_SEG_START[idx[2:0]];
    end
    return tsrs_pkg::TB_SEG_START[idx];
  endfunction

  function automatic logic [9:0] seg_len(input logic mon,
                                         input logic [3:0] idx);
    if (mon) begin
      return tsrs_pkg::MON_SEG_LEN[idx[2:0]];
    end
    return tsrs_pkg::TB_SEG_LEN[idx];
  endfunction

  function automatic logic unlock_match(input logic [15:0] word,
                                        input logic [15:0] val,
                                        input logic [15:0] mask);
    return (word & mask) == val;
  endfunction

  // Decodes of the sequence phases used by the request, flag, configuration, pending, timer and pointer blocks.
  assign clr_tb = (state == tsrs_pkg::ST_CLEAR) && !cur_mon;
  assign clr_mon = (state == tsrs_pkg::ST_CLEAR) && cur_mon;
  assign fin_tb = (state == tsrs_pkg::ST_FINISH) && !cur_mon;
  assign fin_mon = (state == tsrs_pkg::ST_FINISH) && cur_mon;
  assign auto_tb = pin_ok && csum_ok
    && image_pin[tsrs_pkg::BIT_TB_ENABLE]
    && image_cfg[tsrs_pkg::BIT_TB_ENABLE]
    && image_cfg[tsrs_pkg::BIT_TB_RUN];
  assign auto_mon = pin_ok && csum_ok
    && image_pin[tsrs_pkg::BIT_MON_ENABLE]
    && image_cfg[tsrs_pkg::BIT_MON_ENABLE];
  assign host_wr_status = i_host.wr
    && (i_host.addr == tsrs_pkg::ADDR_MASTER_STATUS);
  assign host_wr_cfg = i_host.wr
    && (i_host.addr == tsrs_pkg::ADDR_MASTER_CFG);

  // Soft reset request bits; a new request wins over completion.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tb_req <= 1'b0;
      mon_req <= 1'b0;
    end else begin
      tb_req <= (tb_req && !fin_tb)
        || (host_wr_status && i_host.wdata[tsrs_pkg::BIT_TB_RESET]);
      mon_req <= (mon_req && !fin_mon)
        || (host_wr_status && i_host.wdata[tsrs_pkg::BIT_MON_RESET]);
    end
  end

  // Checksum failure flags, cleared when that terminal resets again.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      tb_err <= 1'b0;
      mon_err <= 1'b0;
    end else begin
      tb_err <= (tb_err && !clr_tb) || (fin_tb && !csum_ok);
      mon_err <= (mon_err && !clr_mon) || (fin_mon && !csum_ok);
    end
  end

  // Sequence controller: clear, read image, reload, check, finish.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state <= tsrs_pkg::ST_IDLE;
      cur_mon <= 1'b0;
      seg <= 4'h0;
      cnt <= 10'h000;
      sum <= 16'h0000;
      img_phase <= 1'b0;
      image_cfg <= 16'h0000;
      image_pin <= 16'h0000;
      csum_ok <= 1'b0;
      o_ee <= '0;
      o_load <= '0;
    end else begin
      o_load.wr <= 1'b0;
      case (state)
        tsrs_pkg::ST_IDLE: begin
          if (tb_req || mon_req) begin
            cur_mon <= !tb_req;
            state <= tsrs_pkg::ST_CLEAR;
          end
        end
        tsrs_pkg::ST_CLEAR: begin
          seg <= 4'h0;
          cnt <= 10'h000;
          sum <= 16'h0000;
          img_phase <= 1'b0;
          o_ee.rd <= 1'b1;
          o_ee.addr <= tsrs_pkg::EE_IMAGE_CFG;
          state <= tsrs_pkg::ST_IMAGE;
        end
        tsrs_pkg::ST_IMAGE: begin
          if (i_ee_valid) begin
            if (!img_phase) begin
              image_cfg <= i_ee_data;
              img_phase <= 1'b1;
              o_ee.addr <= tsrs_pkg::EE_IMAGE_PIN;
            end else begin
              image_pin <= i_ee_data;
              o_ee.addr <= seg_start(cur_mon, 4'h0);
              state <= tsrs_pkg::ST_LOAD;
            end
          end
        end
        tsrs_pkg::ST_LOAD: begin
          if (i_ee_valid) begin
            o_load.wr <= 1'b1;
            o_load.addr <= o_ee.addr;
            o_load.data <= i_ee_data;
            sum <= sum + i_ee_data;
            if (cnt == seg_len(cur_mon, seg) - 10'h001) begin
              cnt <= 10'h000;
              if (seg == (cur_mon ? tsrs_pkg::MON_SEG_LAST
                                  : tsrs_pkg::TB_SEG_LAST)) begin
                o_ee.addr <= cur_mon ? tsrs_pkg::EE_MON_CSUM
                                     : tsrs_pkg::EE_TB_CSUM;
                state <= tsrs_pkg::ST_CHECK;
              end else begin
                seg <= seg + 4'h1;
                o_ee.addr <= seg_start(cur_mon, seg + 4'h1);
              end
            end else begin
              cnt <= cnt + 10'h001;
              o_ee.addr <= seg_start(cur_mon, seg) + {5'h00, cnt} + 15'h0001;
            end
          end
        end
        tsrs_pkg::ST_CHECK: begin
          if (i_ee_valid) begin
            csum_ok <= (sum + i_ee_data) == 16'h0000;
            o_ee.rd <= 1'b0;
            state <= tsrs_pkg::ST_FINISH;
          end
        end
        tsrs_pkg::ST_FINISH: begin
          state <= tsrs_pkg::ST_IDLE;
        end
        default: begin
          state <= tsrs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // The enable pin must stay high for the whole reset.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      pin_ok <= 1'b0;
    end else if (state == tsrs_pkg::ST_CLEAR) begin
      pin_ok <= cur_mon ? i_monitor_enable : i_terminal_b_enable;
    end else if (state != tsrs_pkg::ST_IDLE) begin
      pin_ok <= pin_ok && (cur_mon ? i_monitor_enable
                                   : i_terminal_b_enable);
    end
  end

  // Master configuration: host writes, reset clears and auto-start sets.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_master_cfg <= 16'h0000;
    end else begin
      if (host_wr_cfg) begin
        o_master_cfg <= i_host.wdata;
      end
      if (clr_tb) begin
        o_master_cfg[tsrs_pkg::BIT_TB_RUN] <= 1'b0;
      end
      if (clr_mon) begin
        o_master_cfg[tsrs_pkg::BIT_MON_ENABLE] <= 1'b0;
      end
      if (fin_tb && auto_tb) begin
        o_master_cfg[tsrs_pkg::BIT_TB_RUN] <= 1'b1;
      end
      if (fin_mon && auto_mon) begin
        o_master_cfg[tsrs_pkg::BIT_MON_ENABLE] <= 1'b1;
      end
    end
  end

  // Pending interrupt registers; a new event wins over the reset clear.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      hw_pend <= 16'h0000;
      mon_pend <= 16'h0000;
      rt_pend <= 16'h0000;
    end else begin
      hw_pend <= (hw_pend & ~(
        ({15'h0000, clr_tb} << tsrs_pkg::BIT_PEND_RT)
        | ({15'h0000, clr_tb} << tsrs_pkg::BIT_PEND_TB)
        | ({15'h0000, clr_mon} << tsrs_pkg::BIT_PEND_MON)))
        | i_hw_pend_set;
      mon_pend <= (clr_mon ? 16'h0000 : mon_pend) | i_mon_pend_set;
      rt_pend <= (clr_tb ? (rt_pend & ~tsrs_pkg::RT_PEND_TB_MASK)
                         : rt_pend) | i_rt_pend_set;
    end
  end

  // Terminal B status registers, writable by the host.
  genvar g;
  generate
    for (g = 0; g < tsrs_pkg::TB_CLEAR_REGS; g++) begin : g_tb_reg
      always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || clr_tb) begin
          tb_regs[g] <= 16'h0000;
        end else if (i_host.wr
                     && i_host.addr == tsrs_pkg::TB_CLEAR_ADDR[g]) begin
          tb_regs[g] <= i_host.wdata;
        end
      end
    end
  endgenerate

  // Time tag counters.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || clr_tb) begin
      tb_tt <= 16'h0000;
    end else if (i_tb_tt_tick) begin
      tb_tt <= tb_tt + 16'h0001;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || clr_mon) begin
      mon_tt <= 48'h000000000000;
    end else if (i_mon_tt_tick) begin
      mon_tt <= mon_tt + 48'h000000000001;
    end
  end

  // Monitor stack pointers; stack memory itself is never written here.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || clr_mon) begin
      mon_next_ptr <= 16'h0000;
      mon_last_ptr <= 16'h0000;
    end else if (i_mon_ptr_adv) begin
      mon_last_ptr <= mon_next_ptr;
      mon_next_ptr <= mon_next_ptr + 16'h0001;
    end
  end

  // Image copy path keeps run bits only for matching unlock words.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_copy_cfg_image <= 16'h0000;
    end else begin
      o_copy_cfg_image <= i_copy_cfg;
      o_copy_cfg_image[tsrs_pkg::BIT_TB_RUN] <= i_copy_cfg[tsrs_pkg::BIT_TB_RUN]
        && unlock_match(i_copy_unlock1, tsrs_pkg::TB_UNLOCK1_VAL,
                        tsrs_pkg::TB_UNLOCK_MASK)
        && unlock_match(i_copy_unlock2, tsrs_pkg::TB_UNLOCK2_VAL,
                        tsrs_pkg::TB_UNLOCK_MASK);
      o_copy_cfg_image[tsrs_pkg::BIT_MON_ENABLE] <=
        i_copy_cfg[tsrs_pkg::BIT_MON_ENABLE]
        && unlock_match(i_copy_unlock1, tsrs_pkg::MON_UNLOCK1_VAL,
                        tsrs_pkg::MON_UNLOCK_MASK)
        && unlock_match(i_copy_unlock2, tsrs_pkg::MON_UNLOCK2_VAL,
                        tsrs_pkg::MON_UNLOCK_MASK);
    end
  end

  // Host read multiplexer; unmapped addresses read as zero.
  always_comb begin
    next_rdata = 16'h0000;
    case (i_host.addr)
      tsrs_pkg::ADDR_MASTER_CFG: next_rdata = o_master_cfg;
      tsrs_pkg::ADDR_MASTER_STATUS: begin
        next_rdata[tsrs_pkg::BIT_TB_RESET] = tb_req;
        next_rdata[tsrs_pkg::BIT_MON_RESET] = mon_req;
        next_rdata[tsrs_pkg::BIT_TB_CSUM_ERR] = tb_err;
        next_rdata[tsrs_pkg::BIT_MON_CSUM_ERR] = mon_err;
      end
      tsrs_pkg::ADDR_HW_PEND: next_rdata = hw_pend;
      tsrs_pkg::ADDR_MON_PEND: next_rdata = mon_pend;
      tsrs_pkg::ADDR_RT_PEND: next_rdata = rt_pend;
      tsrs_pkg::ADDR_MON_NEXT_PTR: next_rdata = mon_next_ptr;
      tsrs_pkg::ADDR_MON_LAST_PTR: next_rdata = mon_last_ptr;
      tsrs_pkg::ADDR_MON_TT_LOW: next_rdata = mon_tt[15:0];
      tsrs_pkg::ADDR_MON_TT_MID: next_rdata = mon_tt[31:16];
      tsrs_pkg::ADDR_MON_TT_HIGH: next_rdata = mon_tt[47:32];
      tsrs_pkg::ADDR_TB_TT: next_rdata = tb_tt;
      default: begin
        for (int i = 0; i < tsrs_pkg::TB_CLEAR_REGS; i++) begin
          if (i_host.addr == tsrs_pkg::TB_CLEAR_ADDR[i]) begin
            next_rdata = tb_regs[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_host_rdata <= 16'h0000;
    end else begin
      o_host_rdata <= i_host.rd ? next_rdata : 16'h0000;
    end
  end

  // Ready is registered: high the cycle after the sequencer is idle with no soft reset pending.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_ready <= 1'b0;
    end else begin
      o_ready <= (state == tsrs_pkg::ST_IDLE) && !tb_req && !mon_req;
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  reset_start_a: assert property (
    host_wr_status && i_host.wdata[tsrs_pkg::BIT_TB_RESET] |=> tb_req)
    else $error("Terminal B reset request not taken.");
  pend_clear_a: assert property (
    clr_tb && !host_wr_cfg && i_hw_pend_set == 16'h0000 |=>
      !hw_pend[tsrs_pkg::BIT_PEND_RT] && !hw_pend[tsrs_pkg::BIT_PEND_TB]
      && !o_master_cfg[tsrs_pkg::BIT_TB_RUN])
    else $error("Terminal B pending or run bit not cleared.");
  rt_pend_a: assert property (
    clr_tb && i_rt_pend_set == 16'h0000 |=>
      rt_pend[15:10] == 6'h00 && rt_pend[9:0] == $past(rt_pend[9:0]))
    else $error("Shared pending register cleared wrongly.");
  tb_zero_a: assert property (
    clr_tb |=> tb_regs[0] == 16'h0000 && tb_regs[2] == 16'h0000
      && tb_tt == 16'h0000)
    else $error("Terminal B registers not zeroed.");
  load_write_a: assert property (
    state == tsrs_pkg::ST_LOAD && i_ee_valid |=>
      o_load.wr && o_load.data == $past(i_ee_data)
      && o_load.addr == $past(o_ee.addr))
    else $error("Reloaded word not written out.");
  checksum_a: assert property (
    state == tsrs_pkg::ST_CHECK && i_ee_valid |=>
      csum_ok == ($past(sum + i_ee_data) == 16'h0000))
    else $error("Checksum verdict wrong.");
  no_auto_a: assert property (
    fin_tb && !csum_ok && !host_wr_cfg
      && !$past(o_master_cfg[tsrs_pkg::BIT_TB_RUN]) |=>
      !o_master_cfg[tsrs_pkg::BIT_TB_RUN] && tb_err)
    else $error("Terminal B started after bad checksum.");
  mon_clear_a: assert property (
    clr_mon && i_mon_pend_set == 16'h0000 |=>
      mon_pend == 16'h0000 && mon_next_ptr == 16'h0000
      && mon_tt == 48'h000000000000)
    else $error("Monitor registers not zeroed.");
  copy_lock_a: assert property (
    !unlock_match(i_copy_unlock1, tsrs_pkg::TB_UNLOCK1_VAL,
                  tsrs_pkg::TB_UNLOCK_MASK)
      |=> !o_copy_cfg_image[tsrs_pkg::BIT_TB_RUN])
    else $error("Run bit kept without unlock.");
  ready_busy_a: assert property (
    state != tsrs_pkg::ST_IDLE |=> !o_ready)
    else $error("Ready shown while a reset runs.");

  tb_auto_c: cover property (fin_tb && auto_tb);
  mon_auto_c: cover property (fin_mon && auto_mon);
  both_req_c: cover property (tb_req && mon_req);
  bad_sum_c: cover property (state == tsrs_pkg::ST_FINISH && !csum_ok);

endmodule

// ---- hdl/tsrs_pkg.sv ----
// Purpose: Shared constants and types for the terminal soft reset sequencer.
// Assumes: Word addressing; EEPROM locations mirror register and RAM addresses.
// Notes: Segment tables list every location reloaded by each soft reset.
package tsrs_pkg;

  localparam logic [14:0] ADDR_MASTER_CFG = 15'h0000;
  localparam logic [14:0] ADDR_MASTER_STATUS = 15'h0001;
  localparam logic [14:0] ADDR_HW_PEND = 15'h0006;
  localparam logic [14:0] ADDR_MON_PEND = 15'h0008;
  localparam logic [14:0] ADDR_RT_PEND = 15'h0009;
  localparam logic [14:0] ADDR_MON_NEXT_PTR = 15'h0030;
  localparam logic [14:0] ADDR_MON_LAST_PTR = 15'h0031;
  localparam logic [14:0] ADDR_MON_TT_LOW = 15'h003a;
  localparam logic [14:0] ADDR_MON_TT_MID = 15'h003b;
  localparam logic [14:0] ADDR_MON_TT_HIGH = 15'h003c;
  localparam logic [14:0] ADDR_TB_TT = 15'h004b;

  localparam int TB_CLEAR_REGS = 3;
  localparam logic [14:0] TB_CLEAR_ADDR [0:2] = '{
    15'h0021, 15'h0023, 15'h0027};

  localparam int BIT_TB_RUN = 5;
  localparam int BIT_TB_ENABLE = 7;
  localparam int BIT_MON_ENABLE = 12;
  localparam int BIT_TB_RESET = 11;
  localparam int BIT_MON_RESET = 12;
  localparam int BIT_TB_CSUM_ERR = 13;
  localparam int BIT_MON_CSUM_ERR = 14;
  localparam int BIT_PEND_MON = 1;
  localparam int BIT_PEND_RT = 2;
  localparam int BIT_PEND_TB = 4;
  localparam logic [15:0] RT_PEND_TB_MASK = 16'hfc00;

  localparam logic [14:0] EE_IMAGE_CFG = 15'h0000;
  localparam logic [14:0] EE_IMAGE_PIN = 15'h004f;
  localparam logic [14:0] EE_TB_CSUM = 15'h01e0;
  localparam logic [14:0] EE_MON_CSUM = 15'h005c;

  localparam logic [15:0] TB_UNLOCK1_VAL = 16'ha0ca;
  localparam logic [15:0] TB_UNLOCK2_VAL = 16'h5005;
  localparam logic [15:0] TB_UNLOCK_MASK = 16'hf0cf;
  localparam logic [15:0] MON_UNLOCK1_VAL = 16'ha30a;
  localparam logic [15:0] MON_UNLOCK2_VAL = 16'h5005;
  localparam logic [15:0] MON_UNLOCK_MASK = 16'hf30f;

  localparam logic [3:0] TB_SEG_LAST = 4'ha;
  localparam logic [3:0] MON_SEG_LAST = 4'h7;
  localparam logic [14:0] TB_SEG_START [0:10] = '{
    15'h000f, 15'h0012, 15'h0013, 15'h0016, 15'h0020, 15'h0022,
    15'h0025, 15'h0028, 15'h004c, 15'h0300, 15'h0600};
  localparam logic [9:0] TB_SEG_LEN [0:10] = '{
    10'h001, 10'h001, 10'h001, 10'h001, 10'h001, 10'h001,
    10'h002, 10'h001, 10'h001, 10'h100, 10'h200};
  localparam logic [14:0] MON_SEG_START [0:7] = '{
    15'h000f, 15'h0011, 15'h0013, 15'h0015, 15'h0029, 15'h003d,
    15'h00b0, 15'h0100};
  localparam logic [9:0] MON_SEG_LEN [0:7] = '{
    10'h001, 10'h001, 10'h001, 10'h001, 10'h007, 10'h006,
    10'h010, 10'h080};

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CLEAR = 6'h02,
    ST_IMAGE = 6'h04,
    ST_LOAD = 6'h08,
    ST_CHECK = 6'h10,
    ST_FINISH = 6'h20
  } tsrs_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [14:0] addr;
    logic [15:0] wdata;
  } tsrs_host_req_t;

  typedef struct packed {
    logic rd;
    logic [14:0] addr;
  } tsrs_ee_req_t;

  typedef struct packed {
    logic wr;
    logic [14:0] addr;
    logic [15:0] data;
  } tsrs_load_t;

endpackage

// ---- dv/tsrs_ee_model.sv ----
// Purpose: Serial EEPROM stand-in that answers one word per read request.
// Assumes: The bench fills mem directly and sets the answer delay.
// Notes: Between answers the data lines toggle every cycle, alternating the inverse of the last word and the word itself.
`timescale 1ns/1ps
module tsrs_ee_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire tsrs_pkg::tsrs_ee_req_t i_ee,
  input wire logic [1:0] i_delay,
  output logic o_valid,
  output logic [15:0] o_data
);
  logic [15:0] mem [0:32767];
  logic [1:0] cnt;
  // A word is answered at the earliest one cycle after its address appears.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n || !i_ee.rd || o_valid) begin
      o_valid <= 1'b0;
      cnt <= 2'h0;
      o_data <= i_rst_n ? ~o_data : 16'h0;
    end else if (cnt == i_delay) begin
      o_valid <= 1'b1;
      o_data <= mem[i_ee.addr];
    end else begin
      cnt <= cnt + 2'h1;
      o_data <= ~o_data;
    end
  end
endmodule

// ---- dv/tsrs_sequencer_test.sv ----
// Purpose: Self-checking bench for the soft reset sequencer.
// Assumes: Inputs change on the falling clock edge.
// Notes: Reads and reloads are checked in order from expectation queues.
`timescale 1ns/1ps
module tsrs_sequencer_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  tsrs_pkg::tsrs_host_req_t host = '0;
  tsrs_pkg::tsrs_ee_req_t ee;
  tsrs_pkg::tsrs_load_t load;
  logic [15:0] rdata, cfg_out, cimg, ee_data;
  logic [15:0] hw_s = '0, mon_s = '0, rt_s = '0;
  logic [15:0] c_cfg = '0, c_u1 = '0, c_u2 = '0;
  logic pin_tb = 1'b0, pin_mon = 1'b0, tt_tb = 1'b0, tt_mon = 1'b0;
  logic adv = 1'b0, ee_valid, ready, rd_q = 1'b0;
  logic [1:0] dly = '0;
  logic [15:0] rq [$];
  logic [30:0] lq [$];
  logic [15:0] ex [0:127];
  logic [15:0] cfg_m = '0, stat_m = '0;
  int regs [12] = '{6, 9, 'h21, 'h23, 'h27, 'h4b, 8, 'h30, 'h31, 'h3a,
    'h3b, 'h3c};
  int bad_count = 0, n_compared = 0, cycles = 0;
  int seed = 32'hea5db7d2;

  tsrs_sequencer u_tsrs_sequencer (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_host(host), .o_host_rdata(rdata), .i_terminal_b_enable(pin_tb),
    .i_monitor_enable(pin_mon), .i_hw_pend_set(hw_s),
    .i_mon_pend_set(mon_s), .i_rt_pend_set(rt_s), .i_tb_tt_tick(tt_tb),
    .i_mon_tt_tick(tt_mon), .i_mon_ptr_adv(adv), .o_ee(ee),
    .i_ee_valid(ee_valid), .i_ee_data(ee_data), .o_load(load),
    .o_ready(ready), .o_master_cfg(cfg_out), .i_copy_cfg(c_cfg),
    .i_copy_unlock1(c_u1), .i_copy_unlock2(c_u2),
    .o_copy_cfg_image(cimg));
  tsrs_ee_model u_tsrs_ee_model (.i_ref_clk(clk), .i_rst_n(rst_n),
    .i_ee(ee), .i_delay(dly), .o_valid(ee_valid), .o_data(ee_data));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [30:0] got, input logic [30:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data answers one cycle after the strobe; reloads come in order.
  always @(posedge clk) rd_q <= host.rd;
  always @(negedge clk) begin
    if (rd_q) chk({15'h0, rdata}, {15'h0, rq.pop_front()});
    if (load.wr) chk({load.addr, load.data}, lq.pop_front());
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    @(negedge clk);
    host = '{1'b1, 1'b0, a, d};
    @(negedge clk);
    host = '0;
  endtask

  task automatic rd(input logic [14:0] a, input logic [15:0] e);
    @(negedge clk);
    host = '{1'b0, 1'b1, a, 16'h0};
    rq.push_back(e);
    @(negedge clk);
    host = '0;
  endtask

  task automatic seg(input logic [14:0] st, input logic [9:0] n,
      inout logic [15:0] s);
    logic [14:0] a;
    for (int k = 0; k < int'(n); k++) begin
      a = st + 15'(k);
      s += u_tsrs_ee_model.mem[a];
      lq.push_back({a, u_tsrs_ee_model.mem[a]});
    end
  endtask

  task automatic run(input logic [15:0] req, input logic [1:0] pin,
      input logic [15:0] icfg, ipin, input logic [1:0] bad);
    logic [15:0] r, s0, s1;
    r = 16'($random(seed));
    s0 = '0;
    s1 = '0;
    repeat (2) begin
      @(negedge clk);
      {hw_s, rt_s, mon_s, tt_tb, tt_mon, adv} = {16'h0016, r, ~r, 3'h7};
      @(negedge clk);
      {hw_s, rt_s, mon_s, tt_tb, tt_mon, adv} = '0;
      ex['h31] = ex['h30];
      ex['h30]++;
      ex['h4b]++;
      ex['h3a]++;
    end
    ex[6] |= 16'h0016;
    ex[9] |= r;
    ex[8] |= ~r;
    for (int i = 2; i < 5; i++) begin
      ex[regs[i]] = r + 16'(i);
      wr(15'(regs[i]), ex[regs[i]]);
    end
    for (int a = 0; a < 2048; a++)
      u_tsrs_ee_model.mem[a] = 16'($random(seed));
    if (req[11]) begin
      for (int i = 0; i <= int'(tsrs_pkg::TB_SEG_LAST); i++)
        seg(tsrs_pkg::TB_SEG_START[i], tsrs_pkg::TB_SEG_LEN[i], s0);
      u_tsrs_ee_model.mem[tsrs_pkg::EE_TB_CSUM] = ~s0 + 16'h1 + 16'(bad[0]);
      cfg_m[5] = pin[1] & ipin[7] & icfg[7] & icfg[5] & !bad[0];
      stat_m[13] = bad[0];
      ex[6] &= 16'hffeb;
      ex[9] &= 16'h03ff;
      for (int i = 2; i < 6; i++) ex[regs[i]] = '0;
    end
    if (req[12]) begin
      for (int i = 0; i <= int'(tsrs_pkg::MON_SEG_LAST); i++)
        seg(tsrs_pkg::MON_SEG_START[i], tsrs_pkg::MON_SEG_LEN[i], s1);
      u_tsrs_ee_model.mem[tsrs_pkg::EE_MON_CSUM] = ~s1 + 16'h1 + 16'(bad[1]);
      cfg_m[12] = pin[0] & ipin[12] & icfg[12] & !bad[1];
      stat_m[14] = bad[1];
      ex[6] &= 16'hfffd;
      for (int i = 6; i < 12; i++) ex[regs[i]] = '0;
    end
    u_tsrs_ee_model.mem[tsrs_pkg::EE_IMAGE_CFG] = icfg;
    u_tsrs_ee_model.mem[tsrs_pkg::EE_IMAGE_PIN] = ipin;
    dly = 2'($random(seed));
    {pin_tb, pin_mon} = pin;
    wr(15'h0001, req);
    repeat (3) @(negedge clk);
    for (int t = 0; t < 6000 && ready !== 1'b1; t++) @(negedge clk);
    if (ready !== 1'b1) begin
      bad_count++;
      summarize();
    end
    chk({15'h0, cfg_out}, {15'h0, cfg_m});
    rd(15'h0000, cfg_m);
    rd(15'h0001, stat_m);
    foreach (regs[i]) rd(15'(regs[i]), ex[regs[i]]);
    chk(31'(lq.size()), 31'h0);
    cfg_m[5] |= req[11];
    cfg_m[12] |= req[12];
    wr(15'h0000, cfg_m);
    $display("run done for request %h", req);
  endtask

  task automatic copy_test();
    logic [15:0] u1, u2, e;
    for (int i = 0; i < 8; i++) begin
      u1 = 16'($random(seed));
      u2 = 16'($random(seed));
      e = 16'($random(seed));
      if (i[0]) u1 = (u1 & ~tsrs_pkg::TB_UNLOCK_MASK) | tsrs_pkg::TB_UNLOCK1_VAL;
      if (i[0]) u2 = (u2 & ~tsrs_pkg::TB_UNLOCK_MASK) | tsrs_pkg::TB_UNLOCK2_VAL;
      if (i[1]) u1 = (u1 & ~tsrs_pkg::MON_UNLOCK_MASK) | tsrs_pkg::MON_UNLOCK1_VAL;
      if (i[1]) u2 = (u2 & ~tsrs_pkg::MON_UNLOCK_MASK) | tsrs_pkg::MON_UNLOCK2_VAL;
      @(negedge clk);
      {c_cfg, c_u1, c_u2} = {e, u1, u2};
      if ((u1 & 16'hf0cf) != 16'ha0ca || (u2 & 16'hf0cf) != 16'h5005) e[5] = 0;
      if ((u1 & 16'hf30f) != 16'ha30a || (u2 & 16'hf30f) != 16'h5005) e[12] = 0;
      @(negedge clk);
      chk({15'h0, cimg}, {15'h0, e});
    end
    $display("image copy done");
  endtask

  initial begin
    foreach (ex[i]) ex[i] = '0;
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
    chk(31'(ready), 31'h1);
    wr(15'h0006, 16'hffff);
    rd(15'h0006, 16'h0000);
    rd(15'h7fff, 16'h0000);
    copy_test();
    run(16'h0800, 2'h3, 16'h10a0, 16'h1080, 2'h0);
    run(16'h0800, 2'h1, 16'h10a0, 16'h1080, 2'h0);
    run(16'h0800, 2'h3, 16'h1080, 16'h1080, 2'h0);
    run(16'h0800, 2'h3, 16'h10a0, 16'h1000, 2'h0);
    run(16'h0800, 2'h3, 16'h10a0, 16'h1080, 2'h1);
    run(16'h1000, 2'h3, 16'h10a0, 16'h1080, 2'h0);
    run(16'h1000, 2'h3, 16'h00a0, 16'h1080, 2'h0);
    run(16'h1000, 2'h3, 16'h10a0, 16'h0080, 2'h0);
    run(16'h1800, 2'h3, 16'h10a0, 16'h1080, 2'h2);
    run(16'h1800, 2'h2, 16'h10a0, 16'h1080, 2'h0);
    rd(15'h0000, cfg_m);
    repeat (2) @(negedge clk);
    summarize();
  end
endmodule
